// *** hw/plk_pkg.sv ***
// Shared constants and state type for the PHY-link packet receive/transmit block
package plk_pkg;

  // Control codes driven by the device
  localparam logic [1:0] CTL_IDLE   = 2'h0;
  localparam logic [1:0] CTL_STATUS = 2'h1;
  localparam logic [1:0] CTL_RECV   = 2'h2;
  localparam logic [1:0] CTL_GRANT  = 2'h3;

  // Control codes driven by the link after a grant
  localparam logic [1:0] CTL_HOLD   = 2'h1;
  localparam logic [1:0] CTL_TX     = 2'h2;

  // Data-bus codes, bit 7 is pin D0 so values read as printed D0..D7
  localparam logic [7:0] D_DATA_ON  = 8'hFF;
  localparam logic [7:0] D_S100     = 8'h00;
  localparam logic [7:0] D_S200     = 8'h40;
  localparam logic [7:0] D_S400     = 8'h50;
  localparam logic [7:0] D_ZERO     = 8'h00;

  // Speed index on the serial-side receive port
  localparam logic [1:0] SPD_S100   = 2'h0;
  localparam logic [1:0] SPD_S200   = 2'h1;
  localparam logic [1:0] SPD_S400   = 2'h2;

  // Status word layout: 16 status bits plus a long-transfer flag
  localparam int         STAT_W          = 16;
  localparam int         STAT_WORD_W     = 17;
  localparam int         STAT_LONG_BIT   = 16;
  localparam logic [2:0] STAT_LAST_SHORT = 3'h1;
  localparam logic [2:0] STAT_LAST_LONG  = 3'h7;

  // Minimum packet separation before a concatenation grant, in link cycles
  localparam int         SEP_CYC  = 8;
  localparam logic [5:0] SEP_LAST = 6'(SEP_CYC - 1);

  // Interface sequencer states
  typedef enum logic [3:0] {
    ST_IDLE,
    ST_GAP,
    ST_STAT,
    ST_RX_ON,
    ST_RX_DATA,
    ST_GRANT,
    ST_GIDLE,
    ST_TURN,
    ST_TURN2,
    ST_PRE,
    ST_TXD,
    ST_LEND,
    ST_SEP
  } plk_state_e;

endpackage

// *** hw/plk_word_if.sv ***
// Word channel between the core-side producer and the link-side consumer
`timescale 1ns/1ns
interface plk_word_if;
  import plk_pkg::*;

  logic                   src_valid;
  logic                   src_ready;
  logic [STAT_WORD_W-1:0] src_data;
  logic                   dst_valid;
  logic                   dst_ready;
  logic [STAT_WORD_W-1:0] dst_data;

  modport user (
    output src_valid,
    output src_data,
    output dst_ready,
    input  src_ready,
    input  dst_valid,
    input  dst_data
  );

  modport sync (
    input  src_valid,
    input  src_data,
    input  dst_ready,
    output src_ready,
    output dst_valid,
    output dst_data
  );

endinterface

// *** hw/plk_word_sync.sv ***
// Toggle handshake that carries one status word from core clock to link clock
`timescale 1ns/1ns
module plk_word_sync
  import plk_pkg::*;
(
  // Clocks and resets
  input  wire logic core_clk,
  input  wire logic arst_n,
  input  wire logic link_clk,
  input  wire logic link_rst_n,
  // Word channel
  plk_word_if.sync  chan
);

  logic                   req;
  logic [STAT_WORD_W-1:0] hold;
  logic                   ack_m;
  logic                   ack_s;
  logic                   req_m;
  logic                   req_s;
  logic                   ack;

  // Word stays in hold until acknowledged, so the link side may read it directly
  wire pending = req ^ ack_s;

  assign chan.src_ready = !pending;
  assign chan.dst_valid = req_s ^ ack;
  assign chan.dst_data  = hold;

  // Core side: launch a word only when the previous one came back
  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      req  <= 1'b0;
      hold <= '0;
    end
    else if (chan.src_valid && !pending)
    begin
      req  <= !req;
      hold <= chan.src_data;
    end
  end

  // Acknowledge toggle back into the core domain
  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      ack_m <= 1'b0;
      ack_s <= 1'b0;
    end
    else
    begin
      ack_m <= ack;
      ack_s <= ack_m;
    end
  end

  // Request toggle into the link domain, then consume
  always_ff @(posedge link_clk or negedge link_rst_n)
  begin
    if (!link_rst_n)
    begin
      req_m <= 1'b0;
      req_s <= 1'b0;
      ack   <= 1'b0;
    end
    else
    begin
      req_m <= req;
      req_s <= req_m;
      if (chan.dst_valid && chan.dst_ready)
        ack <= !ack;
    end
  end

endmodule

// *** hw/plk_phy_link.sv ***
// Device end of the PHY-link interface: receive, status and transmit handshakes
// How it works
// RL1 - On data-prefix start receive: CTL Receive, all D lines high.
// RL2 - Speed code on D exactly one cycle right before packet data.
// RL3 - CTL stays Receive until last symbol passed, then Idle ends data.
// RL4 - Speed code is framing only, never part of the packet data path.
// RL5 - Null packet: Receive with data-on, then Idle, no speed or data.
// RL6 - Data-on shown at least one cycle before speed code or end.
// RL7 - Own self-ID packet is passed up like any received packet.
// RL8 - A receive may cut a status transfer: Status goes straight to Receive.
// RL9 - Link takes speed from first Receive cycle not showing data-on.
// RL10 - At least one Idle cycle after every receive.
// RL11 - Arbitration won: Grant one cycle, Idle one cycle, then release pins.
// RL12 - Link drives Idle, Hold or Transmit after taking the interface.
// RL13 - Link: at most one Idle, up to 47 Holds, then Transmit.
// RL14 - While the link holds before transmitting, send data-prefix serially.
// RL15 - Link: Transmit data, then Hold or Idle, then Idle, then release.
// RL16 - Ending Hold means concatenate: keep bus, wait separation, grant again.
// RL17 - Link keeps one speed per ownership unless multispeed is enabled.
// RL18 - With multispeed enabled the link gives next speed on D at ending Hold.
// RL19 - Link never concatenates an S100 packet after a faster one.
// RL20 - On link release, drive Idle one clock after sampling its Idle.
// RL21 - After regaining the pins drive Idle before status, receive or grant.
// RL22 - One spare clock on every change of pin driving direction.
// RL23 - Status transfers drive Status code 01b on CTL.
// RL24 - Idle is 00b and Receive is 10b on CTL.
`timescale 1ns/1ns
module plk_phy_link
  import plk_pkg::*;
(
  // Core clock and reset
  input  wire logic              core_clk,
  input  wire logic              arst_n,
  // Core-side status words and mode
  input  wire logic              stat_valid,
  output logic                   stat_ready,
  input  wire logic [STAT_W-1:0] stat_word,
  input  wire logic              stat_long,
  input  wire logic              multispeed_concat_enable,
  // Link clock
  input  wire logic              link_clk,
  // Serial-side receive events
  input  wire logic              rx_start,
  input  wire logic              rx_spd_valid,
  input  wire logic [1:0]        rx_speed,
  input  wire logic              rx_valid,
  input  wire logic [7:0]        rx_byte,
  input  wire logic              rx_end,
  // Serial-side transmit events
  input  wire logic              arb_won,
  output logic                   tx_prefix,
  output logic                   tx_valid,
  output logic [7:0]             tx_byte,
  output logic                   tx_end,
  output logic                   tx_concat,
  output logic                   tx_next_spd_valid,
  output logic [7:0]             tx_next_spd,
  output logic                   tx_release,
  // PHY-link pins
  input  wire logic [1:0]        ctl_in,
  output logic [1:0]             ctl_out,
  output logic                   ctl_oe_n,
  input  wire logic [7:0]        d_in,
  output logic [7:0]             d_out,
  output logic                   d_oe_n
);

  plk_word_if word ();

  plk_state_e state;
  plk_state_e next_state;
  logic       rst_m;
  logic       link_rst_n;
  logic       msc_m;
  logic       msc_s;
  logic [1:0] ctl_r;
  logic [7:0] d_r;
  logic [1:0] ctl_q;
  logic [1:0] next_ctl;
  logic [7:0] d_q;
  logic [7:0] next_d;
  logic       oe_q;
  logic       next_oe;
  logic [2:0] stat_cnt;
  logic [2:0] next_stat_cnt;
  logic [5:0] sep_cnt;
  logic [5:0] next_sep_cnt;
  logic       idle_seen;
  logic       next_idle_seen;
  logic       concat_pend;
  logic       next_concat_pend;
  logic       stat_take;
  logic       next_tx_prefix;
  logic       next_tx_valid;
  logic [7:0] next_tx_byte;
  logic       next_tx_end;
  logic       next_tx_concat;
  logic       next_tx_spd_valid;
  logic [7:0] next_tx_spd;
  logic       next_tx_release;

  // Core-side producer onto the word channel
  assign word.src_valid = stat_valid;
  assign word.src_data  = {stat_long, stat_word};
  assign word.dst_ready = stat_take;
  assign stat_ready     = word.src_ready;

  plk_word_sync u_sync (
    .core_clk   (core_clk),
    .arst_n     (arst_n),
    .link_clk   (link_clk),
    .link_rst_n (link_rst_n),
    .chan       (word.sync)
  );

  // Pin outputs come straight from the output registers
  assign ctl_out  = ctl_q;
  assign d_out    = d_q;
  assign ctl_oe_n = oe_q;
  assign d_oe_n   = oe_q;

  // Decode of the registered link-side copy of CTL
  wire link_idle = (ctl_r == CTL_IDLE);
  wire link_hold = (ctl_r == CTL_HOLD);
  wire link_tx   = (ctl_r == CTL_TX);

  // Speed index to D code; an unknown index falls back to the slowest code
  wire [7:0] rx_spd_code = (rx_speed == SPD_S400) ? D_S400 :
                           (rx_speed == SPD_S200) ? D_S200 : D_S100;

  // Status pair selection: even bit on D0, odd bit on D1
  wire [STAT_W-1:0] stat_bits = word.dst_data[STAT_W-1:0];
  wire [2:0]        stat_last = word.dst_data[STAT_LONG_BIT] ? STAT_LAST_LONG : STAT_LAST_SHORT;
  wire [2:0]        pair_idx  = (state == ST_STAT) ? 3'(stat_cnt + 3'h1) : 3'h0;
  wire [7:0]        stat_pair = {stat_bits[{pair_idx, 1'b0}], stat_bits[{pair_idx, 1'b1}], 6'h00};

  // Link-domain reset: asynchronous assert, release synchronised to link_clk
  always_ff @(posedge link_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      rst_m      <= 1'b0;
      link_rst_n <= 1'b0;
    end
    else
    begin
      rst_m      <= 1'b1;
      link_rst_n <= rst_m;
    end
  end

  // Mode level crosses by two flops; registered copies of the link pins
  always_ff @(posedge link_clk or negedge link_rst_n)
  begin
    if (!link_rst_n)
    begin
      msc_m <= 1'b0;
      msc_s <= 1'b0;
      ctl_r <= CTL_IDLE;
      d_r   <= D_ZERO;
    end
    else
    begin
      msc_m <= multispeed_concat_enable;
      msc_s <= msc_m;
      ctl_r <= ctl_in;        // Decisions use only registered pins [RL22]
      d_r   <= d_in;
    end
  end

  // Sequencer: one case over the interface phases
  always_comb
  begin
    next_state        = state;
    next_ctl          = ctl_q;
    next_d            = d_q;
    next_oe           = oe_q;
    next_stat_cnt     = stat_cnt;
    next_sep_cnt      = sep_cnt;
    next_idle_seen    = idle_seen;
    next_concat_pend  = concat_pend;
    stat_take         = 1'b0;
    next_tx_prefix    = 1'b0;
    next_tx_valid     = 1'b0;
    next_tx_byte      = tx_byte;
    next_tx_end       = 1'b0;
    next_tx_concat    = tx_concat;
    next_tx_spd_valid = 1'b0;
    next_tx_spd       = tx_next_spd;
    next_tx_release   = 1'b0;
    unique case (state)
      // Interface idle; the gap state bars a status directly after a transfer
      ST_IDLE, ST_GAP:
      begin
        next_ctl = CTL_IDLE;                        // [RL24]
        next_d   = D_ZERO;
        next_oe  = 1'b0;
        if (rx_start)
        begin
          next_ctl   = CTL_RECV;                    // Own self-ID too, no filter [RL1] [RL7]
          next_d     = D_DATA_ON;
          next_state = ST_RX_ON;
        end
        else if (arb_won)
        begin
          next_ctl   = CTL_GRANT;                   // [RL11]
          next_state = ST_GRANT;
        end
        else if (state == ST_IDLE && word.dst_valid)
        begin
          next_ctl      = CTL_STATUS;               // [RL23]
          next_d        = stat_pair;
          next_stat_cnt = pair_idx;
          next_state    = ST_STAT;
        end
        else
          next_state = ST_IDLE;
      end
      // Status pairs; an interrupted word is retried whole later
      ST_STAT:
      begin
        if (rx_start)
        begin
          next_ctl      = CTL_RECV;                 // No Idle between [RL8]
          next_d        = D_DATA_ON;
          next_stat_cnt = 3'h0;
          next_state    = ST_RX_ON;
        end
        else if (stat_cnt == stat_last)
        begin
          next_ctl      = CTL_IDLE;
          next_d        = D_ZERO;
          next_stat_cnt = 3'h0;
          stat_take     = 1'b1;
          next_state    = ST_GAP;
        end
        else
        begin
          next_d        = stat_pair;
          next_stat_cnt = pair_idx;
        end
      end
      // Data-on shown since the previous edge, so at least one cycle [RL6]
      ST_RX_ON:
      begin
        if (rx_end)
        begin
          next_ctl   = CTL_IDLE;                    // Null packet [RL5] [RL10]
          next_d     = D_ZERO;
          next_state = ST_GAP;
        end
        else if (rx_spd_valid)
        begin
          next_d     = rx_spd_code;                 // One cycle, data follows [RL2]
          next_state = ST_RX_DATA;
        end
      end
      // Payload only; the speed code never reaches this byte path
      ST_RX_DATA:
      begin
        if (rx_end)
        begin
          next_ctl   = CTL_IDLE;                    // End after last symbol [RL3] [RL10]
          next_d     = D_ZERO;
          next_state = ST_GAP;
        end
        else if (rx_valid)
          next_d = rx_byte;                         // [RL4]
      end
      // Grant lasted one cycle, now one Idle
      ST_GRANT:
      begin
        next_ctl   = CTL_IDLE;                      // [RL11]
        next_d     = D_ZERO;
        next_state = ST_GIDLE;
      end
      ST_GIDLE:
      begin
        next_oe    = 1'b1;                          // Release pins [RL11]
        next_state = ST_TURN;
      end
      // Spare cycle plus register stage before the link's first cycle counts
      ST_TURN:
        next_state = ST_TURN2;                      // [RL22]
      ST_TURN2:
      begin
        next_idle_seen = 1'b0;
        next_state     = ST_PRE;
      end
      // Before Transmit: optional Idle and Holds, or an immediate release
      ST_PRE:
      begin
        if (link_tx)
        begin
          next_tx_valid = 1'b1;
          next_tx_byte  = d_r;
          next_state    = ST_TXD;
        end
        else if (link_hold)
        begin
          next_tx_prefix = 1'b1;                    // [RL14]
          next_idle_seen = 1'b1;
        end
        else if (link_idle && idle_seen)
          next_state = ST_LEND;
        else if (link_idle)
          next_idle_seen = 1'b1;
      end
      // Transmit data until the link ends the packet
      ST_TXD:
      begin
        if (link_tx)
        begin
          next_tx_valid = 1'b1;
          next_tx_byte  = d_r;
        end
        else
        begin
          next_tx_end      = 1'b1;
          next_tx_concat   = link_hold;             // [RL16]
          next_concat_pend = link_hold;
          if (link_hold && msc_s)
          begin
            next_tx_spd_valid = 1'b1;
            next_tx_spd       = d_r;
          end
          next_state = ST_LEND;
        end
      end
      // Wait for the link's closing Idle, then take the pins back
      ST_LEND:
      begin
        if (link_idle)
        begin
          next_oe    = 1'b0;                        // One clock after its Idle [RL20]
          next_ctl   = CTL_IDLE;                    // [RL21]
          next_d     = D_ZERO;
          next_state = concat_pend ? ST_SEP : ST_GAP;
          next_tx_release = !concat_pend;
          next_sep_cnt    = 6'h00;
        end
      end
      // Keep the serial bus through the separation time, then grant again
      ST_SEP:
      begin
        if (sep_cnt == SEP_LAST)
        begin
          next_ctl         = CTL_GRANT;             // [RL16]
          next_concat_pend = 1'b0;
          next_state       = ST_GRANT;
        end
        else
          next_sep_cnt = 6'(sep_cnt + 6'h01);
      end
    endcase
  end

  // Sequencer state and pin registers
  always_ff @(posedge link_clk or negedge link_rst_n)
  begin
    if (!link_rst_n)
    begin
      state       <= ST_GAP;
      ctl_q       <= CTL_IDLE;
      d_q         <= D_ZERO;
      oe_q        <= 1'b0;
      stat_cnt    <= 3'h0;
      sep_cnt     <= 6'h00;
      idle_seen   <= 1'b0;
      concat_pend <= 1'b0;
    end
    else
    begin
      state       <= next_state;
      ctl_q       <= next_ctl;
      d_q         <= next_d;
      oe_q        <= next_oe;
      stat_cnt    <= next_stat_cnt;
      sep_cnt     <= next_sep_cnt;
      idle_seen   <= next_idle_seen;
      concat_pend <= next_concat_pend;
    end
  end

  // Serial-side transmit outputs, all registered
  always_ff @(posedge link_clk or negedge link_rst_n)
  begin
    if (!link_rst_n)
    begin
      tx_prefix         <= 1'b0;
      tx_valid          <= 1'b0;
      tx_byte           <= D_ZERO;
      tx_end            <= 1'b0;
      tx_concat         <= 1'b0;
      tx_next_spd_valid <= 1'b0;
      tx_next_spd       <= D_S100;
      tx_release        <= 1'b0;
    end
    else
    begin
      tx_prefix         <= next_tx_prefix;
      tx_valid          <= next_tx_valid;
      tx_byte           <= next_tx_byte;
      tx_end            <= next_tx_end;
      tx_concat         <= next_tx_concat;
      tx_next_spd_valid <= next_tx_spd_valid;
      tx_next_spd       <= next_tx_spd;
      tx_release        <= next_tx_release;
    end
  end

endmodule

// *** verif/plk_phy_link_sva.sv ***
// Checker for the device side of the PHY-link pin handshakes
`timescale 1ns/1ns
module plk_phy_link_sva
  import plk_pkg::*;
(
  // Link clock and reset
  input wire logic       link_clk,
  input wire logic       arst_n,
  // Serial-side events
  input wire logic       rx_start,
  input wire logic       rx_spd_valid,
  input wire logic [1:0] rx_speed,
  input wire logic       rx_valid,
  input wire logic [7:0] rx_byte,
  input wire logic       rx_end,
  input wire logic       tx_concat,
  input wire logic       tx_release,
  // Pins
  input wire logic [1:0] ctl_out,
  input wire logic       ctl_oe_n,
  input wire logic [7:0] d_out,
  input wire logic       d_oe_n
);
  default clocking @(posedge link_clk); endclocking
  default disable iff (!arst_n);

  // Link owns the bus from grant to release; receive start is refused then
  logic own;

  // Ownership tracker
  always_ff @(posedge link_clk or negedge arst_n)
  begin
    if (!arst_n)
      own <= 1'b0;
    else if (ctl_out == CTL_GRANT)
      own <= 1'b1;
    else if (tx_release)
      own <= 1'b0;
  end

  // Speed index to pin code, unknown index falls back to the slowest
  function automatic logic [7:0] spd_code(input logic [1:0] s);
    return (s == SPD_S200) ? D_S200 : (s == SPD_S400) ? D_S400 : D_S100;
  endfunction

  a_rx_data_on: assert property (rx_start && !own && !ctl_oe_n && ctl_out != CTL_RECV
    |=> ctl_out == CTL_RECV && d_out == D_DATA_ON)
    else $error("receive start without data-on");
  a_speed_code: assert property (rx_spd_valid && ctl_out == CTL_RECV && d_out == D_DATA_ON
    |=> ctl_out == CTL_RECV && d_out == spd_code($past(rx_speed)))
    else $error("wrong speed code");
  a_byte_pass: assert property (rx_valid && ctl_out == CTL_RECV
    |=> ctl_out == CTL_RECV && d_out == $past(rx_byte))
    else $error("payload byte not passed");
  a_rx_end_idle: assert property (rx_end && ctl_out == CTL_RECV
    |=> ctl_out == CTL_IDLE && !ctl_oe_n)
    else $error("receive not closed by idle");
  a_grant_seq: assert property (ctl_out == CTL_GRANT && !ctl_oe_n
    |=> ctl_out == CTL_IDLE && !ctl_oe_n ##1 ctl_oe_n && d_oe_n)
    else $error("grant sequence broken");
  a_idle_first: assert property (ctl_out == CTL_GRANT && !ctl_oe_n
    |-> $past(ctl_out) == CTL_IDLE && !$past(ctl_oe_n))
    else $error("grant without idle before");
  a_status_start: assert property (ctl_out == CTL_STATUS && $past(ctl_out) != CTL_STATUS
    |-> $past(ctl_out) == CTL_IDLE && d_out[5:0] == 6'h00)
    else $error("status not after idle");
  a_concat_grant: assert property ($fell(ctl_oe_n) && tx_concat
    |-> (ctl_out == CTL_IDLE) [*7] ##[1:3] ctl_out == CTL_GRANT)
    else $error("no grant after concatenation");
  a_release_idle: assert property ($fell(ctl_oe_n) && !tx_concat
    |-> tx_release && ctl_out == CTL_IDLE && !d_oe_n)
    else $error("release not answered by idle");

  // Main scenarios
  c_speed: cover property (rx_spd_valid && ctl_out == CTL_RECV);
  c_null: cover property (rx_end && ctl_out == CTL_RECV && d_out == D_DATA_ON);
  c_cut: cover property ($past(ctl_out) == CTL_STATUS && ctl_out == CTL_RECV);
  c_concat: cover property ($fell(ctl_oe_n) && tx_concat);
endmodule

bind plk_phy_link plk_phy_link_sva u_sva (.link_clk, .arst_n, .rx_start, .rx_spd_valid,
  .rx_speed, .rx_valid, .rx_byte, .rx_end, .tx_concat, .tx_release, .ctl_out, .ctl_oe_n,
  .d_out, .d_oe_n);

// *** verif/plk_link_model.sv ***
// Behavioural link-layer controller on the far side of the pins
`timescale 1ns/1ns
module plk_link_model
  import plk_pkg::*;
(
  // Link clock
  input wire logic       link_clk,
  // Device pins
  input wire logic [1:0] ctl_out,
  input wire logic       ctl_oe_n,
  input wire logic [7:0] d_out,
  input wire logic       d_oe_n,
  // Resolved pin levels
  output logic [1:0]     ctl_in,
  output logic [7:0]     d_in
);
  logic       drv;
  logic [1:0] lc;
  logic [7:0] ld;
  logic [1:0] last_c;
  logic [7:0] last_d;
  int         pkt;

  // Undriven pins toggle each cycle so a stale level never reads as valid
  assign ctl_in = !ctl_oe_n ? ctl_out : drv ? lc : ~last_c;
  assign d_in   = !d_oe_n ? d_out : drv ? ld : ~last_d;

  // Last wire level
  always @(posedge link_clk)
  begin
    last_c <= ctl_in;
    last_d <= d_in;
  end

  // One link cycle on the pins
  task automatic put(input logic [1:0] c, input logic [7:0] d);
    @(negedge link_clk);
    drv = 1'b1;
    lc  = c;
    ld  = d;
  endtask

  // First packet: idle, 47 holds, data, ending hold; second: data, ending idle
  initial
  begin
    drv = 1'b0;
    lc  = CTL_IDLE;
    ld  = D_ZERO;
    pkt = 0;
    forever
    begin
      @(posedge link_clk);
      if (ctl_out === CTL_GRANT && ctl_oe_n === 1'b0)
      begin
        repeat (2) @(posedge link_clk);
        if (pkt == 0)
          put(CTL_IDLE, D_ZERO);
        repeat ((pkt == 0) ? 47 : 0) put(CTL_HOLD, D_ZERO);
        for (int i = 0; i < 3; i++)
          put(CTL_TX, 8'(8'hA0 + i));
        put((pkt == 0) ? CTL_HOLD : CTL_IDLE, (pkt == 0) ? D_S400 : D_ZERO);
        put(CTL_IDLE, D_ZERO);
        @(negedge link_clk);
        drv = 1'b0;
        pkt++;
      end
    end
  end
endmodule

// *** verif/plk_phy_link_bench.sv ***
// Self-checking bench for the PHY-link packet receive and transmit block
`timescale 1ns/1ns
module plk_phy_link_bench
  import plk_pkg::*;
;
  typedef struct {logic [1:0] spd; logic [7:0] code; int n;} plk_rx_row_s;
  logic        core_clk, arst_n, link_clk, stat_valid, stat_ready, stat_long, msc;
  logic [15:0] stat_word;
  logic        rx_start, rx_spd_valid, rx_valid, rx_end, arb_won;
  logic [1:0]  rx_speed, ctl_in, ctl_out;
  logic [7:0]  rx_byte, d_in, d_out, tx_byte, tx_next_spd;
  logic        tx_prefix, tx_valid, tx_end, tx_concat, tx_next_spd_valid, tx_release;
  logic        ctl_oe_n, d_oe_n;
  int          fail_count, comparisons, cycles, tx_idx, n_pref, n_end, k;
  // Speed index, pin code, payload length (0 is a null packet)
  plk_rx_row_s rows [5] = '{'{SPD_S100, D_S100, 2}, '{SPD_S200, D_S200, 1},
    '{SPD_S400, D_S400, 4}, '{2'h3, D_S100, 1}, '{SPD_S100, D_S100, 0}};

  plk_phy_link u_dut (.core_clk, .arst_n, .stat_valid, .stat_ready, .stat_word, .stat_long,
    .multispeed_concat_enable(msc), .link_clk, .rx_start, .rx_spd_valid, .rx_speed,
    .rx_valid, .rx_byte, .rx_end, .arb_won, .tx_prefix, .tx_valid, .tx_byte, .tx_end,
    .tx_concat, .tx_next_spd_valid, .tx_next_spd, .tx_release, .ctl_in, .ctl_out,
    .ctl_oe_n, .d_in, .d_out, .d_oe_n);
  plk_link_model u_lnk (.link_clk, .ctl_out, .ctl_oe_n, .d_out, .d_oe_n, .ctl_in, .d_in);

  // Clocks: 125 ns link period split as evenly as whole nanoseconds allow
  always #5 core_clk = ~core_clk;
  always
  begin
    #62 link_clk = ~link_clk;
    #63 link_clk = ~link_clk;
  end

  task print_verdict();
    if (fail_count == 0 && comparisons > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  // Called from two processes at once, hence automatic
  task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
    comparisons++;
    if (got !== exp)
    begin
      fail_count++;
      $display("unexpected %s: expected %h seen %h", nm, exp, got);
    end
  endtask

  task lk(input int n);
    repeat (n) @(negedge link_clk);
  endtask

  // Bounded wait for a control code on the pins
  task wait_ctl(input logic [1:0] c);
    k = 0;
    while (ctl_out !== c && k < 400)
    begin
      lk(1);
      k++;
    end
    chk("wait ctl", 16'(c), 16'(ctl_out));
  endtask

  task rx_pkt(input plk_rx_row_s r);
    rx_start = 1'b1;
    lk(1);
    rx_start = 1'b0;
    chk("rx ctl", 16'(CTL_RECV), 16'(ctl_out));
    chk("data on", 16'(D_DATA_ON), 16'(d_out));
    if (r.n > 0)
    begin
      rx_spd_valid = 1'b1;
      rx_speed = r.spd;
      lk(1);
      rx_spd_valid = 1'b0;
      chk("speed", 16'(r.code), 16'(d_out));
      for (int i = 0; i < r.n; i++)
      begin
        rx_valid = 1'b1;
        rx_byte = 8'(8'hC0 + i);
        lk(1);
        rx_valid = 1'b0;
        chk("rx byte", 16'(8'hC0 + i), 16'(d_out));
      end
    end
    rx_end = 1'b1;
    lk(1);
    rx_end = 1'b0;
    chk("rx end", 16'(CTL_IDLE), 16'(ctl_out));
  endtask

  // Offer one status word and wait until stat_ready drops as it is accepted
  task send_stat(input logic [15:0] w, input logic lng);
    @(negedge core_clk);
    stat_word = w;
    stat_long = lng;
    stat_valid = 1'b1;
    k = 0;
    do
    begin
      @(negedge core_clk);
      k++;
    end
    while (stat_ready !== 1'b0 && k < 50);
    stat_valid = 1'b0;
  endtask

  // Status bit pairs, even bit on D0
  task chk_stat(input logic [15:0] w, input int np);
    wait_ctl(CTL_STATUS);
    for (int p = 0; p < np; p++)
    begin
      chk("status d", 16'({w[2*p], w[2*p+1], 6'h00}), 16'(d_out));
      lk(1);
    end
    chk("status end", 16'(CTL_IDLE), 16'(ctl_out));
  endtask

  // Transmit-side observations
  always @(negedge link_clk)
  begin
    if (tx_valid === 1'b1)
    begin
      chk("tx byte", 16'(8'hA0 + tx_idx), 16'(tx_byte));
      tx_idx++;
    end
    if (tx_prefix === 1'b1)
      n_pref++;
    if (tx_next_spd_valid === 1'b1)
      chk("next speed", 16'(D_S400), 16'(tx_next_spd));
    if (tx_end === 1'b1)
    begin
      chk("concat", 16'(n_end == 0), 16'(tx_concat));
      tx_idx = 0;
      n_end++;
    end
  end

  // Hang guard
  always @(posedge core_clk)
  begin
    cycles++;
    if (cycles == 40000)
    begin
      fail_count++;
      print_verdict();
    end
  end

  initial
  begin
    {core_clk, link_clk, arst_n, stat_valid, stat_long, rx_start} = '0;
    {rx_spd_valid, rx_valid, rx_end, arb_won, rx_speed, rx_byte} = '0;
    {fail_count, comparisons, cycles, tx_idx, n_pref, n_end} = '0;
    stat_word = 16'h0000;
    msc = 1'b1;
    lk(6);
    arst_n = 1'b1;
    lk(3);
    chk("reset ctl", 16'(CTL_IDLE), 16'(ctl_out));
    chk("reset oe", 16'h0000, 16'(ctl_oe_n));
    chk("reset ready", 16'h0001, 16'(stat_ready));
    foreach (rows[i])
    begin
      rx_pkt(rows[i]);
      lk(2);
    end
    send_stat(16'h0009, 1'b0);
    chk_stat(16'h0009, 2);
    send_stat(16'hA5C3, 1'b1);
    chk_stat(16'hA5C3, 8);
    // Receive cuts a long status transfer, which is then sent again whole
    send_stat(16'h3C96, 1'b1);
    wait_ctl(CTL_STATUS);
    lk(2);
    chk("cut status", 16'(CTL_STATUS), 16'(ctl_out));
    rx_pkt(rows[4]);
    chk_stat(16'h3C96, 8);
    lk(3);
    arb_won = 1'b1;
    lk(1);
    arb_won = 1'b0;
    chk("grant", 16'(CTL_GRANT), 16'(ctl_out));
    lk(1);
    chk("grant idle", 16'(CTL_IDLE), 16'(ctl_out));
    lk(1);
    chk("released", 16'h0001, 16'(ctl_oe_n));
    k = 0;
    while (tx_release !== 1'b1 && k < 600)
    begin
      lk(1);
      k++;
    end
    chk("tx release", 16'h0001, 16'(tx_release));
    chk("take ctl", 16'(CTL_IDLE), 16'({ctl_oe_n, ctl_out}));
    lk(2);
    chk("prefix cycles", 16'd47, 16'(n_pref));
    chk("packets", 16'd2, 16'(n_end));
    print_verdict();
  end
endmodule
